// *** inc/cimac_pkg.sv ***
// shared constants for the complex integer multiply-accumulate block
package cimac_pkg;

  // build-time option defaults
  localparam int INT_SIZE_DEF    = 16;
  localparam int OUT_WIDTH_DEF   = 32;
  localparam int PIPE_STAGES_DEF = 0;
  localparam int PIPE_STAGES_MAX = 2;
  localparam int ADDR_W          = 12;
  localparam int DATA_W          = 32;

  // operand signedness option values
  localparam bit OPT_SIGNED   = 1'b0;
  localparam bit OPT_UNSIGNED = 1'b1;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFSET        = 12'h000;
  localparam logic [ADDR_W-1:0] RESULT_REAL_OFFSET = 12'h004;
  localparam logic [ADDR_W-1:0] RESULT_IMAG_OFFSET = 12'h008;

  // control register layout and value after reset
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_LOAD_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // width of the helper counter that tracks undisturbed pipeline cycles
  localparam int QUIET_W = 3;

endpackage : cimac_pkg

// *** verilog/cimac_mult.sv ***
// full-precision complex product of two integer operands
`timescale 1ns/1ps

module cimac_mult #(
  parameter int N         = cimac_pkg::INT_SIZE_DEF,
  parameter int OUT_W     = cimac_pkg::OUT_WIDTH_DEF,
  parameter bit A_UNS     = cimac_pkg::OPT_SIGNED,
  parameter bit B_UNS     = cimac_pkg::OPT_SIGNED,
  parameter bit CONJ      = 1'b0
) (
  input  wire logic [N-1:0]         a_re,
  input  wire logic [N-1:0]         a_im,
  input  wire logic [N-1:0]         b_re,
  input  wire logic [N-1:0]         b_im,
  output logic signed [OUT_W-1:0]   prod_re,
  output logic signed [OUT_W-1:0]   prod_im
);
  import cimac_pkg::*;

  localparam int EW = N + 1;
  localparam int PW = 2 * N + 3;

  // one extra bit lets signed and unsigned parts share one signed multiplier
  function automatic logic signed [EW-1:0] ext(input logic [N-1:0] x,
                                               input bit uns);
    ext = uns ? {1'b0, x} : {x[N-1], x};
  endfunction

  logic signed [EW-1:0]   ar, ai, br, bi;
  logic signed [2*N+1:0]  rr, ii, ri, ir;
  logic signed [PW-1:0]   re_full, im_full;

  // each part extended by its own operand's signedness
  assign ar = ext(a_re, A_UNS);
  assign ai = ext(a_im, A_UNS);
  assign br = ext(b_re, B_UNS);
  assign bi = ext(b_im, B_UNS);

  // four partial products, exact at 2n+2 bits
  assign rr = ar * br;
  assign ii = ai * bi;
  assign ri = ar * bi;
  assign ir = ai * br;

  // conjugate flips the sign of every term that carries b imaginary
  assign re_full = CONJ ? PW'(rr) + PW'(ii) : PW'(rr) - PW'(ii);
  assign im_full = CONJ ? PW'(ir) - PW'(ri) : PW'(ir) + PW'(ri);

  // narrower outputs keep the low bits, wider ones sign-extend
  assign prod_re = OUT_W'(re_full);
  assign prod_im = OUT_W'(im_full);

endmodule // cimac_mult

// *** verilog/cimac_apb_regs.sv ***
// apb slave holding control and result readback registers
`timescale 1ns/1ps

module cimac_apb_regs #(
  parameter int OUT_W = cimac_pkg::OUT_WIDTH_DEF
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [cimac_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [cimac_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic                               pready,
  output logic [cimac_pkg::DATA_W-1:0]       prdata,
  output logic                               pslverr,
  input  wire logic [OUT_W-1:0]              res_re,
  input  wire logic [OUT_W-1:0]              res_im,
  output logic                               run,
  output logic                               load_pulse
);
  import cimac_pkg::*;

  typedef struct packed {
    logic              run;
    logic              load_pulse;
    logic              err;
    logic [DATA_W-1:0] rdata;
  } cimac_apb_st_t;

  cimac_apb_st_t s, next_s;

  logic              hit_ctrl, hit_re, hit_im, wr_acc;
  logic [DATA_W-1:0] rd_mux;

  function automatic logic [DATA_W-1:0] widen(input logic [OUT_W-1:0] v);
    widen = DATA_W'(v);
  endfunction

  // address decode; anything else answers with pslverr
  assign hit_ctrl = (paddr == CTRL_OFFSET);
  assign hit_re   = (paddr == RESULT_REAL_OFFSET);
  assign hit_im   = (paddr == RESULT_IMAG_OFFSET);
  assign wr_acc   = psel & penable & pwrite;

  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) begin
      rd_mux = {30'h0, 1'b0, s.run};
    end else if (hit_re) begin
      rd_mux = widen(res_re);
    end else if (hit_im) begin
      rd_mux = widen(res_im);
    end
  end

  // read data captured in setup, so access never waits
  always_comb begin
    next_s = s;
    next_s.load_pulse = 1'b0;
    if (psel & ~penable) begin
      next_s.rdata = pwrite ? '0 : rd_mux;
      next_s.err   = ~(hit_ctrl | hit_re | hit_im) | (pwrite & ~hit_ctrl);
    end
    if (wr_acc & hit_ctrl & pstrb[0]) begin
      next_s.run        = pwdata[CTRL_RUN_BIT];
      next_s.load_pulse = pwdata[CTRL_LOAD_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{run: CTRL_RESET[CTRL_RUN_BIT], load_pulse: 1'b0,
             err: 1'b0, rdata: '0};
    end else begin
      s <= next_s;
    end
  end

  assign pready     = 1'b1;
  assign prdata     = s.rdata;
  assign pslverr    = psel & penable & s.err;
  assign run        = s.run;
  assign load_pulse = s.load_pulse;

endmodule // cimac_apb_regs

// *** verilog/cimac_top.sv ***
// complex integer multiplier with optional input registers and accumulator
`timescale 1ns/1ps

module cimac_top #(
  parameter int N           = cimac_pkg::INT_SIZE_DEF,
  parameter int OUT_W       = cimac_pkg::OUT_WIDTH_DEF,
  parameter bit A_UNS       = cimac_pkg::OPT_SIGNED,
  parameter bit B_UNS       = cimac_pkg::OPT_SIGNED,
  parameter bit CONJ        = 1'b0,
  parameter bit ACC_EN      = 1'b0,
  parameter bit IN_REG      = 1'b0,
  parameter bit HIDE_IN     = 1'b0,
  parameter int PIPE_STAGES = cimac_pkg::PIPE_STAGES_DEF,
  parameter bit HIDE_PIPE   = 1'b0
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [cimac_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [cimac_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic                               pready,
  output logic [cimac_pkg::DATA_W-1:0]       prdata,
  output logic                               pslverr,
  input  wire logic [N-1:0]                  operand_a_real,
  input  wire logic [N-1:0]                  operand_a_imag,
  input  wire logic [N-1:0]                  operand_b_real,
  input  wire logic [N-1:0]                  operand_b_imag,
  input  wire logic                          load,
  input  wire logic                          in_reg_a_ce,
  input  wire logic                          in_reg_b_ce,
  input  wire logic                          in_reg_rstn,
  input  wire logic                          pipeline_ce,
  input  wire logic                          pipeline_rstn,
  output logic signed [OUT_W-1:0]            result_real,
  output logic signed [OUT_W-1:0]            result_imag
);
  import cimac_pkg::*;

  // total latency from operand pins to result pins
  localparam int LAT  = PIPE_STAGES + (IN_REG ? 1 : 0);
  // latency from operand pins to the summing point
  localparam int LATS = (IN_REG ? 1 : 0) + (PIPE_STAGES == 2 ? 1 : 0);

  typedef struct packed {
    logic [N-1:0]             a_re;
    logic [N-1:0]             a_im;
    logic [N-1:0]             b_re;
    logic [N-1:0]             b_im;
    logic                     ld_in;
    logic signed [OUT_W-1:0]  mid_re;
    logic signed [OUT_W-1:0]  mid_im;
    logic                     ld_mid;
    logic signed [OUT_W-1:0]  acc_re;
    logic signed [OUT_W-1:0]  acc_im;
    logic [QUIET_W-1:0]       quiet;
  } cimac_st_t;

  cimac_st_t s, next_s;

  logic                     a_ce, b_ce, in_rstn, pce, prstn;
  logic                     run, load_pulse, load_eff;
  logic [N-1:0]             op_a_re, op_a_im, op_b_re, op_b_im;
  logic signed [OUT_W-1:0]  prod_re, prod_im, raw_re, raw_im;
  logic signed [OUT_W-1:0]  pre_re, pre_im, sum_re, sum_im;
  logic                     ld0, ldp, undisturbed;

  // hidden controls sit at logic one inside the block
  assign a_ce    = HIDE_IN ? 1'b1 : in_reg_a_ce;
  assign b_ce    = HIDE_IN ? 1'b1 : in_reg_b_ce;
  assign in_rstn = HIDE_IN ? 1'b1 : in_reg_rstn;
  // clearing the run bit freezes the pipeline and accumulator
  assign pce     = (HIDE_PIPE ? 1'b1 : pipeline_ce) & run;
  assign prstn   = HIDE_PIPE ? 1'b1 : pipeline_rstn;
  assign load_eff = load | load_pulse;

  cimac_apb_regs #(
    .OUT_W (OUT_W)
  ) u_regs (
    .pclk       (pclk),
    .presetn    (presetn),
    .paddr      (paddr),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .pwdata     (pwdata),
    .pstrb      (pstrb),
    .pready     (pready),
    .prdata     (prdata),
    .pslverr    (pslverr),
    .res_re     (result_real),
    .res_im     (result_imag),
    .run        (run),
    .load_pulse (load_pulse)
  );

  // operands come from the input registers or straight from the pins
  assign op_a_re = IN_REG ? s.a_re : operand_a_real;
  assign op_a_im = IN_REG ? s.a_im : operand_a_imag;
  assign op_b_re = IN_REG ? s.b_re : operand_b_real;
  assign op_b_im = IN_REG ? s.b_im : operand_b_imag;
  assign ld0     = IN_REG ? s.ld_in : load_eff;

  cimac_mult #(
    .N     (N),
    .OUT_W (OUT_W),
    .A_UNS (A_UNS),
    .B_UNS (B_UNS),
    .CONJ  (CONJ)
  ) u_mult (
    .a_re    (op_a_re),
    .a_im    (op_a_im),
    .b_re    (op_b_re),
    .b_im    (op_b_im),
    .prod_re (prod_re),
    .prod_im (prod_im)
  );

  // reference product of the raw pins, read only by the checks below
  cimac_mult #(
    .N     (N),
    .OUT_W (OUT_W),
    .A_UNS (A_UNS),
    .B_UNS (B_UNS),
    .CONJ  (CONJ)
  ) u_ref (
    .a_re    (operand_a_real),
    .a_im    (operand_a_imag),
    .b_re    (operand_b_real),
    .b_im    (operand_b_imag),
    .prod_re (raw_re),
    .prod_im (raw_im)
  );

  // with two stages one register sits before the summing point
  assign pre_re = (PIPE_STAGES == 2) ? s.mid_re : prod_re;
  assign pre_im = (PIPE_STAGES == 2) ? s.mid_im : prod_im;
  assign ldp    = (PIPE_STAGES == 2) ? s.ld_mid : ld0;

  // load drops the old sum so the product starts a fresh one
  always_comb begin
    if (ACC_EN && !ldp) begin
      sum_re = s.acc_re + pre_re;
      sum_im = s.acc_im + pre_im;
    end else begin
      sum_re = pre_re;
      sum_im = pre_im;
    end
  end

  // all pipeline controls calm, counted for the latency checks
  assign undisturbed = a_ce & b_ce & in_rstn & pce & prstn;

  // next state: input registers, middle stage, accumulator
  always_comb begin
    next_s = s;
    if (!in_rstn) begin
      next_s.a_re  = '0;
      next_s.a_im  = '0;
      next_s.b_re  = '0;
      next_s.b_im  = '0;
      next_s.ld_in = 1'b0;
    end else begin
      if (a_ce) begin
        next_s.a_re = operand_a_real;
        next_s.a_im = operand_a_imag;
      end
      if (b_ce) begin
        next_s.b_re = operand_b_real;
        next_s.b_im = operand_b_imag;
      end
      // the strobe rides along with whichever operand advances
      if (a_ce | b_ce) begin
        next_s.ld_in = load_eff;
      end
    end
    if (!prstn) begin
      next_s.mid_re = '0;
      next_s.mid_im = '0;
      next_s.ld_mid = 1'b0;
      next_s.acc_re = '0;
      next_s.acc_im = '0;
    end else if (pce) begin
      next_s.mid_re = prod_re;
      next_s.mid_im = prod_im;
      next_s.ld_mid = ld0;
      next_s.acc_re = sum_re;
      next_s.acc_im = sum_im;
    end
    if (!undisturbed) begin
      next_s.quiet = '0;
    end else if (s.quiet != {QUIET_W{1'b1}}) begin
      next_s.quiet = s.quiet + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // with no pipeline stage the sum goes out unregistered
  assign result_real = (PIPE_STAGES >= 1) ? s.acc_re : sum_re;
  assign result_imag = (PIPE_STAGES >= 1) ? s.acc_im : sum_im;

  // a input register holds while its enable is low
  property p_a_hold;
    @(posedge pclk) disable iff (!presetn)
      (IN_REG && in_rstn && !a_ce) |=> $stable(s.a_re) && $stable(s.a_im);
  endproperty
  a_a_hold: assert property (p_a_hold)
    else $error("a input register moved with enable low");

  // b input register loads the pins while its enable is high
  property p_b_load;
    @(posedge pclk) disable iff (!presetn)
      (IN_REG && in_rstn && b_ce) |=> s.b_re == $past(operand_b_real);
  endproperty
  a_b_load: assert property (p_b_load)
    else $error("b input register did not load");

  // synchronous clear of both operand registers
  property p_in_clear;
    @(posedge pclk) disable iff (!presetn)
      (IN_REG && !in_rstn) |=> (s.a_re == '0) && (s.b_im == '0);
  endproperty
  a_in_clear: assert property (p_in_clear)
    else $error("input registers not cleared by input reset");

  // hidden controls keep the input registers loading every cycle
  property p_hidden;
    @(posedge pclk) disable iff (!presetn)
      (IN_REG && HIDE_IN) |=> s.a_im == $past(operand_a_imag);
  endproperty
  a_hidden: assert property (p_hidden)
    else $error("hidden input controls not tied high");

  generate
    if (LAT > 0) begin : g_lat
      // result equals the pin product exactly LAT cycles earlier
      property p_latency;
        @(posedge pclk) disable iff (!presetn)
          (!ACC_EN && s.quiet >= QUIET_W'(LAT)) |->
            (result_real == $past(raw_re, LAT)) &&
            (result_imag == $past(raw_im, LAT));
      endproperty
      a_latency: assert property (p_latency)
        else $error("result does not match product at latency");
    end
    if (LATS > 0) begin : g_lds
      // load reaches the summing point with its own product
      property p_load_delay;
        @(posedge pclk) disable iff (!presetn)
          (s.quiet >= QUIET_W'(LATS)) |-> ldp == $past(load_eff, LATS);
      endproperty
      a_load_delay: assert property (p_load_delay)
        else $error("load strobe misaligned with product");
    end
  endgenerate

  // running sum adds each product when no load is seen
  property p_accum;
    @(posedge pclk) disable iff (!presetn)
      (ACC_EN && prstn && pce && !ldp) |=>
        s.acc_re == $past(s.acc_re) + $past(pre_re);
  endproperty
  a_accum: assert property (p_accum)
    else $error("accumulator did not add the product");

  // load discards the previous sum
  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      (ACC_EN && prstn && pce && ldp) |=> s.acc_im == $past(pre_im);
  endproperty
  a_restart: assert property (p_restart)
    else $error("load did not restart the accumulation");

  // without accumulation each product stands alone
  property p_no_acc;
    @(posedge pclk) disable iff (!presetn)
      (!ACC_EN && prstn && pce) |=> s.acc_re == $past(pre_re);
  endproperty
  a_no_acc: assert property (p_no_acc)
    else $error("plain product depends on an earlier result");

endmodule // cimac_top

// *** bench/cimac_feeder.sv ***
// user datapath model that feeds operand pairs to the multiplier
`timescale 1ns/1ps
module cimac_feeder (
  input  wire logic        pclk,
  output logic      [15:0] a_re,
  output logic      [15:0] a_im,
  output logic      [15:0] b_re,
  output logic      [15:0] b_im,
  output logic             ld,
  output logic             ce_a,
  output logic             ce_b,
  output logic             rstn
);
  // quiet pair at start, enables up, input reset released
  initial begin
    {a_re, a_im, b_re, b_im, ld} = '0;
    {ce_a, ce_b, rstn} = 3'h7;
  end

  // one pair per clock, changed right after an edge and held a full cycle
  task automatic present(input logic [15:0] ar, ai, br, bi,
                         input logic l, ca, cb, rn);
    @(posedge pclk);
    a_re <= ar;
    a_im <= ai;
    b_re <= br;
    b_im <= bi;
    ld   <= l;
    ce_a <= ca;
    ce_b <= cb;
    rstn <= rn;
  endtask
endmodule // cimac_feeder

// *** bench/tb.sv ***
// self-checking bench for the complex multiply-accumulate block
`timescale 1ns/1ps
module tb;
  import cimac_pkg::*;
  typedef struct {
    logic [15:0] ar, ai, br, bi;
    logic        ld, ca, cb, rn;
  } cimac_step_t;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic        [11:0] paddr = '0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic        [31:0] pwdata = '0;
  logic               pready;
  logic        [31:0] prdata;
  logic               pslverr;
  logic        [15:0] a_re, a_im, b_re, b_im;
  logic        [15:0] m_ar = '0, m_ai = '0, m_br = '0, m_bi = '0;
  logic               ld, ce_a, ce_b, in_rstn;
  logic        [3:0]  pstrb = 4'h1;
  logic               pipe_ce = 1'b1;
  logic               pipe_rstn = 1'b1;
  logic signed [31:0] result_real, result_imag, p_re, p_im;
  int                 fail_count = 0;
  int                 total_checks = 0;
  cimac_step_t        seq[$];

  // 20 MHz clock
  always #25 pclk = ~pclk;

  cimac_feeder cimac_feeder_inst (.pclk(pclk), .a_re(a_re), .a_im(a_im),
    .b_re(b_re), .b_im(b_im), .ld(ld), .ce_a(ce_a), .ce_b(ce_b),
    .rstn(in_rstn));

  // unsigned a, signed b, conjugate, accumulate, input regs, one stage
  cimac_top #(.A_UNS(1'b1), .CONJ(1'b1), .ACC_EN(1'b1), .IN_REG(1'b1),
    .PIPE_STAGES(1)) cimac_top_inst (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .operand_a_real(a_re), .operand_a_imag(a_im),
    .operand_b_real(b_re), .operand_b_imag(b_im), .load(ld),
    .in_reg_a_ce(ce_a), .in_reg_b_ce(ce_b), .in_reg_rstn(in_rstn),
    .pipeline_ce(pipe_ce), .pipeline_rstn(pipe_rstn),
    .result_real(result_real),
    .result_imag(result_imag));

  // second build: signed a, unsigned b, hidden controls, two stages
  if (1'b1) begin : g_plain
    cimac_top #(.B_UNS(1'b1), .IN_REG(1'b1), .HIDE_IN(1'b1),
      .PIPE_STAGES(2), .HIDE_PIPE(1'b1)) cimac_top_inst (.pclk(pclk),
      .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(),
      .prdata(), .pslverr(), .operand_a_real(m_ar), .operand_a_imag(m_ai),
      .operand_b_real(m_br), .operand_b_imag(m_bi), .load(ld),
      .in_reg_a_ce(ce_a), .in_reg_b_ce(ce_b), .in_reg_rstn(in_rstn),
      .pipeline_ce(pipe_ce), .pipeline_rstn(pipe_rstn),
      .result_real(p_re), .result_imag(p_im));
  end

  function automatic longint ext(logic [15:0] v, bit u);
    return u ? longint'(v) : longint'($signed(v));
  endfunction

  // reference complex product at full precision
  function automatic void cprod(input logic [15:0] ar, ai, br, bi,
                                input bit au, bu, cj,
                                output longint re, im);
    longint yi;
    yi = cj ? -ext(bi, bu) : ext(bi, bu);
    re = ext(ar, au) * ext(br, bu) - ext(ai, au) * yi;
    im = ext(ar, au) * yi + ext(ai, au) * ext(br, bu);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // apb master: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] adr,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic put(input cimac_step_t s);
    cimac_feeder_inst.present(s.ar, s.ai, s.br, s.bi, s.ld, s.ca, s.cb,
                              s.rn);
  endtask

  // drives the queued pairs; a tb copy of the input regs and accumulator
  // predicts each result two edges after its pair
  task automatic run_seq(input string name);
    longint      pr, pi, acc_r, acc_i;
    logic [15:0] ra_r, ra_i, rb_r, rb_i;
    logic        l;
    logic [31:0] exp_r [$];
    logic [31:0] exp_i [$];
    {ra_r, ra_i, rb_r, rb_i} = '0;
    acc_r = 0;
    acc_i = 0;
    l = 1'b0;
    foreach (seq[k]) begin
      put(seq[k]);
      // the staged strobe clears with the operands, moves with an enable
      if (!seq[k].rn) begin
        {ra_r, ra_i, rb_r, rb_i} = '0;
        l = 1'b0;
      end else begin
        if (seq[k].ca) {ra_r, ra_i} = {seq[k].ar, seq[k].ai};
        if (seq[k].cb) {rb_r, rb_i} = {seq[k].br, seq[k].bi};
        if (seq[k].ca | seq[k].cb) l = seq[k].ld;
      end
      cprod(ra_r, ra_i, rb_r, rb_i, 1'b1, 1'b0, 1'b1, pr, pi);
      acc_r = l ? pr : acc_r + pr;
      acc_i = l ? pi : acc_i + pi;
      exp_r.push_back(acc_r[31:0]);
      exp_i.push_back(acc_i[31:0]);
      #1;
      if (k >= 2) begin
        chk({name, " real"}, exp_r[k-2], result_real);
        chk({name, " imag"}, exp_i[k-2], result_imag);
      end
    end
    $display("test %s finished", name);
  endtask

  task automatic t_plain;
    logic [15:0] v [12] = '{16'h8000, 16'h8000, 16'h7fff, 16'hffff,
      16'hffff, 16'h0001, 16'h8000, 16'h0002, 16'h1234, 16'hedcc,
      16'hfff0, 16'h0100};
    longint re, im;
    for (int i = 0; i < 12; i += 4) begin
      @(posedge pclk);
      {m_ar, m_ai, m_br, m_bi} <= {v[i], v[i+1], v[i+2], v[i+3]};
      // input register plus two stages: result three edges later
      repeat (3) @(posedge pclk);
      #1;
      cprod(v[i], v[i+1], v[i+2], v[i+3], 1'b0, 1'b1, 1'b0, re, im);
      chk("plain real", re[31:0], p_re);
      chk("plain imag", im[31:0], p_im);
    end
    $display("test plain finished");
  endtask

  task automatic t_accum;
    seq = {};
    seq.push_back('{16'hffff, 16'h8001, 16'h8000, 16'h7fff, 1, 1, 1, 1});
    seq.push_back('{16'h0003, 16'h0005, 16'hfffe, 16'h0007, 0, 1, 1, 1});
    seq.push_back('{16'h1000, 16'h00ff, 16'h0100, 16'hff00, 0, 1, 1, 1});
    seq.push_back('{16'h0042, 16'hc000, 16'h7fff, 16'h8000, 1, 1, 1, 1});
    seq.push_back('{16'h0011, 16'h0022, 16'h0033, 16'hffcc, 0, 1, 1, 1});
    seq.push_back(seq[0]);
    seq.push_back(seq[3]);
    run_seq("accumulate");
  endtask

  // enables hold one operand; input reset clears both before the next use
  task automatic t_enables;
    seq = {};
    seq.push_back('{16'h0102, 16'h0304, 16'hfff9, 16'h0006, 1, 1, 1, 1});
    seq.push_back('{16'h0abc, 16'h0def, 16'h0011, 16'hff22, 1, 0, 1, 1});
    seq.push_back('{16'h8001, 16'h7002, 16'h0033, 16'h0044, 1, 1, 0, 1});
    seq.push_back('{16'h0000, 16'h0000, 16'h1111, 16'h2222, 1, 1, 1, 1});
    seq.push_back('{16'h5555, 16'haaaa, 16'h3333, 16'h4444, 1, 1, 1, 0});
    seq.push_back('{16'h9999, 16'h8888, 16'h0077, 16'hff66, 1, 0, 1, 1});
    seq.push_back('{16'h0123, 16'h4567, 16'h0aaa, 16'h0bbb, 1, 1, 0, 1});
    seq.push_back('{16'h0123, 16'h4567, 16'h0aaa, 16'h0bbb, 0, 1, 1, 1});
    repeat (2) seq.push_back(seq[6]);
    run_seq("enables");
  endtask

  task automatic t_apb;
    logic [31:0] rd;
    logic        err;
    longint      pr, pi, qr, qi;
    cimac_step_t p, q;
    p = '{16'h1234, 16'hfedc, 16'h8000, 16'h0101, 1, 1, 1, 1};
    q = '{16'h00ff, 16'h0002, 16'h7fff, 16'hff00, 1, 1, 1, 1};
    cprod(p.ar, p.ai, p.br, p.bi, 1'b1, 1'b0, 1'b1, pr, pi);
    cprod(q.ar, q.ai, q.br, q.bi, 1'b1, 1'b0, 1'b1, qr, qi);
    repeat (3) put(p);
    apb(1'b0, CTRL_OFFSET, '0, rd, err);
    chk("ctrl reset value", 32'(CTRL_RESET), rd);
    apb(1'b0, RESULT_REAL_OFFSET, '0, rd, err);
    chk("real readback", pr[31:0], rd);
    apb(1'b0, RESULT_IMAG_OFFSET, '0, rd, err);
    chk("imag readback", pi[31:0], rd);
    apb(1'b0, 12'h00c, '0, rd, err);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, RESULT_REAL_OFFSET, 32'h0, rd, err);
    chk("read-only error", 32'h1, {31'h0, err});
    // run cleared: the result must not follow the new pair
    apb(1'b1, CTRL_OFFSET, 32'h0, rd, err);
    repeat (3) put(q);
    #1;
    chk("frozen result", pr[31:0], result_real);
    apb(1'b1, CTRL_OFFSET, 32'h1, rd, err);
    repeat (2) put(q);
    #1;
    chk("resumed result", qi[31:0], result_imag);
    // register load pulse restarts a sum the pins keep adding to
    q.ld = 1'b0;
    repeat (2) put(q);
    apb(1'b1, CTRL_OFFSET, 32'h3, rd, err);
    repeat (2) @(posedge pclk);
    #1;
    chk("load pulse restart", qi[31:0], result_imag);
    $display("test register access finished");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // main sequence after a five-cycle reset
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_plain();
    t_accum();
    t_enables();
    t_apb();
    results();
  end

  // watchdog at 2000 cycles, far beyond the fewer than one hundred cycles the tests need
  initial begin
    #100000;
    fail_count++;
    results();
  end
endmodule // tb
